// File: serial_transceiver.sv
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
// Summary of operation
// - ninth bit carried both directions
// - empty flag tracks transmit buffer occupancy
// - empty interrupt requested while flag set
// - data write clears empty flag
// - complete flag set when all shifted out (code: set as the stop bit starts, on the last tick of LINE_STOP)
// - complete cleared by service or one
// - complete interrupt when flag set, enabled
// - parity bit after data, before stop
// - transmitter disable waits for empty path
// - receiver enable takes receive pin
// - synchronous mode samples on external clock
// - sample through first stop, ignore second
// - first stop moves frame into buffer
// - unused upper data bits read zero
// - ninth bit and errors stored per entry
// - receive complete means buffer not empty
// - receiver disable flushes buffer
// - receive interrupt requested while flag set
// - two-entry buffer, overrun on fourth start
// - parity is xor, inverted for odd
// - frame error when first stop low
module serial_transceiver
    import serial_pkg::*;
(
    input  wire logic        aclk,          // system clock
    input  wire logic        aresetn,       // synchronous reset, low
    input  wire logic [7:0]  s_axi_awaddr,  // write address
    input  wire logic        s_axi_awvalid, // write address valid
    output logic             s_axi_awready, // write address ready
    input  wire logic [31:0] s_axi_wdata,   // write data
    input  wire logic [3:0]  s_axi_wstrb,   // write strobes
    input  wire logic        s_axi_wvalid,  // write data valid
    output logic             s_axi_wready,  // write data ready
    output logic [1:0]       s_axi_bresp,   // write response
    output logic             s_axi_bvalid,  // write response valid
    input  wire logic        s_axi_bready,  // write response ready
    input  wire logic [7:0]  s_axi_araddr,  // read address
    input  wire logic        s_axi_arvalid, // read address valid
    output logic             s_axi_arready, // read address ready
    output logic [31:0]      s_axi_rdata,   // read data
    output logic [1:0]       s_axi_rresp,   // read response
    output logic             s_axi_rvalid,  // read valid
    input  wire logic        s_axi_rready,  // read ready
    input  wire logic        rx_pin,        // serial receive line
    input  wire logic        sync_transfer_clock_pin, // external clock
    input  wire logic        tx_complete_ack, // complete interrupt serviced
    output logic             tx_pin_out,    // serial transmit line
    output logic             tx_pin_oe,     // transmitter owns pin
    output logic             rx_pin_owned,  // receiver owns pin
    output logic             irq_rx_complete, // receive interrupt
    output logic             irq_tx_empty,  // buffer empty interrupt
    output logic             irq_tx_complete // transmit complete interrupt
);

    ////////////////////////////////////////////////////////////////////////
    // registers and state
    logic [7:0]  ctrl_b;
    logic [7:0]  ctrl_c;
    logic [15:0] baud_div;
    logic [15:0] baud_cnt;
    logic        tick;
    logic [8:0]  tx_buf;
    logic        tx_buffer_empty_flag;
    logic        tx_complete_flag;
    line_state_t tx_state;
    logic [8:0]  tx_shift;
    logic [3:0]  tx_bit;
    logic        tx_par;
    line_state_t rx_state;
    logic [8:0]  rx_shift;
    logic [3:0]  rx_bit;
    logic        rx_par_err;
    logic        rx_hold;
    rx_entry_t   rx_held;
    rx_entry_t   rx_fifo [RX_DEPTH];
    logic [1:0]  rx_count;
    logic        rx_rd_ptr;
    logic        overrun_pend;
    logic [2:0]  rx_sync;
    logic [2:0]  xck_sync;
    logic        rx_s;
    logic        xck_rise;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic        wr_do;
    logic        rd_data;
    logic        next_tx_load;

    logic        transmitter_enable;
    logic        receiver_enable;
    logic        parity_enable_bit;
    logic        parity_odd_select;
    logic [2:0]  character_size_code;
    logic [3:0]  nbits;
    logic        rx_complete_flag;
    rx_entry_t   rx_head;
    logic        bit_tick;

    assign transmitter_enable  = ctrl_b[TXEN_POS];
    assign receiver_enable     = ctrl_b[RXEN_POS];
    assign parity_enable_bit   = ctrl_c[PEN_POS];
    assign parity_odd_select   = ctrl_c[PODD_POS];
    assign character_size_code = ctrl_c[SIZE_LSB +: 3];
    assign rx_complete_flag    = (rx_count != 2'd0);
    assign rx_head             = rx_fifo[rx_rd_ptr];

    // data bits per character from the size code
    function automatic logic [3:0] size_bits(input logic [2:0] code);
        if (code == SIZE_NINE) begin
            return 4'd9;
        end else if (code > SIZE_EIGHT) begin
            return 4'd8;
        end else begin
            return 4'(code) + 4'd5;
        end
    endfunction : size_bits

    // mask characters below eight bits
    function automatic logic [8:0] mask_data(input logic [8:0] d, input logic [3:0] n);
        return d & 9'((10'h1 << n) - 10'h1);
    endfunction : mask_data

    assign nbits = size_bits(character_size_code);

    // head character with unused upper bits cleared
    logic [8:0]  rx_head_masked;
    assign rx_head_masked = mask_data(rx_head.data, nbits);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers and bit clock
    always_ff @(posedge aclk) begin
        rx_sync  <= {rx_sync[1:0], rx_pin};
        xck_sync <= {xck_sync[1:0], sync_transfer_clock_pin};
    end
    assign rx_s     = rx_sync[1];
    assign xck_rise = xck_sync[1] & ~xck_sync[2];

    // internal baud divider, one-cycle tick per bit
    always_ff @(posedge aclk) begin
        if (!aresetn || baud_cnt == 16'h0000) begin
            baud_cnt <= aresetn ? baud_div : BAUD_RESET;
        end else begin
            baud_cnt <= baud_cnt - 16'h0001;
        end
    end
    assign tick     = aresetn && baud_cnt == 16'h0000;
    assign bit_tick = ctrl_c[SYNC_POS] ? xck_rise : tick;

    ////////////////////////////////////////////////////////////////////////
    // lite bus handshake
    assign wr_do   = aw_got && w_got && !s_axi_bvalid;
    assign rd_data = s_axi_arvalid && s_axi_arready
                     && s_axi_araddr == ADDR_DATA && rx_complete_flag;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            w_got  <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got  <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got  <= 1'b1;
                w_data <= s_axi_wdata;
            end
            if (wr_do) begin
                aw_got <= 1'b0;
                w_got  <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr <= ADDR_BAUD) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_got && aresetn;
    assign s_axi_wready  = !w_got && aresetn;

    // read answer one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            if (s_axi_araddr == ADDR_DATA) begin
                s_axi_rdata[7:0] <= rx_head_masked[7:0];
            end else if (s_axi_araddr == ADDR_STATUS_A) begin
                s_axi_rdata[RXC_POS]  <= rx_complete_flag;
                s_axi_rdata[TXC_POS]  <= tx_complete_flag;
                s_axi_rdata[UDRE_POS] <= tx_buffer_empty_flag;
                s_axi_rdata[FE_POS]   <= rx_complete_flag & rx_head.frame_err;
                s_axi_rdata[DOR_POS]  <= rx_complete_flag & rx_head.overrun;
                s_axi_rdata[PE_POS]   <= rx_complete_flag & rx_head.parity_err;
            end else if (s_axi_araddr == ADDR_CTRL_B) begin
                s_axi_rdata[7:0]      <= ctrl_b;
                s_axi_rdata[RXB8_POS] <= rx_head.data[8];
            end else if (s_axi_araddr == ADDR_CTRL_C) begin
                s_axi_rdata[7:0] <= ctrl_c;
            end else if (s_axi_araddr == ADDR_BAUD) begin
                s_axi_rdata[15:0] <= baud_div;
            end else begin
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid && aresetn;

    // control registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_b   <= 8'h00;
            ctrl_c   <= {5'h00, SIZE_EIGHT};
            baud_div <= BAUD_RESET;
        end else if (wr_do && w_data_ok()) begin
            if (aw_addr == ADDR_CTRL_B) begin
                ctrl_b <= w_data[7:0] & ~8'(1 << RXB8_POS);
            end else if (aw_addr == ADDR_CTRL_C) begin
                ctrl_c <= w_data[7:0];
            end else if (aw_addr == ADDR_BAUD) begin
                baud_div <= w_data[15:0];
            end
        end
    end

    function automatic logic w_data_ok();
        return s_axi_wstrb != 4'h0 || w_got;
    endfunction : w_data_ok

    ////////////////////////////////////////////////////////////////////////
    // transmit buffer and flags
    assign next_tx_load = !tx_buffer_empty_flag && tx_state == LINE_IDLE
                          && transmitter_enable;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_buffer_empty_flag <= 1'b1;
            tx_buf <= 9'h000;
        end else if (wr_do && aw_addr == ADDR_DATA) begin
            tx_buf <= {ctrl_b[TXB8_POS], w_data[7:0]};
            tx_buffer_empty_flag <= 1'b0;
        end else if (next_tx_load) begin
            tx_buffer_empty_flag <= 1'b1;
        end
    end

    // complete flag: set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_complete_flag <= 1'b0;
        end else if (tx_state == LINE_STOP && bit_tick && tx_buffer_empty_flag) begin
            tx_complete_flag <= 1'b1;
        end else if (tx_complete_ack
                     || (wr_do && aw_addr == ADDR_STATUS_A && w_data[TXC_POS])) begin
            tx_complete_flag <= 1'b0;
        end
    end

    // transmit shifter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_state <= LINE_IDLE;
            tx_shift <= 9'h000;
            tx_bit   <= 4'd0;
            tx_par   <= 1'b0;
            tx_pin_out <= 1'b1;
        end else begin
            case (tx_state)
                LINE_IDLE: begin
                    tx_pin_out <= 1'b1;
                    if (next_tx_load) begin
                        tx_shift <= mask_data(tx_buf, nbits);
                        tx_par   <= ^mask_data(tx_buf, nbits) ^ parity_odd_select;
                        tx_state <= LINE_START;
                    end
                end
                LINE_START: if (bit_tick) begin
                    tx_pin_out <= 1'b0;
                    tx_bit   <= 4'd0;
                    tx_state <= LINE_DATA;
                end
                LINE_DATA: if (bit_tick) begin
                    tx_pin_out <= tx_shift[0];
                    tx_shift <= tx_shift >> 1;
                    tx_bit   <= tx_bit + 4'd1;
                    if (tx_bit == nbits - 4'd1) begin
                        tx_state <= parity_enable_bit ? LINE_PARITY : LINE_STOP;
                    end
                end
                LINE_PARITY: if (bit_tick) begin
                    tx_pin_out <= tx_par;
                    tx_state <= LINE_STOP;
                end
                LINE_STOP: if (bit_tick) begin
                    tx_pin_out <= 1'b1;
                    tx_state <= LINE_IDLE;
                end
                default: tx_state <= LINE_IDLE;
            endcase
        end
    end

    // pin released only once shifter and buffer are empty
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_pin_oe <= 1'b0;
        end else if (transmitter_enable) begin
            tx_pin_oe <= 1'b1;
        end else if (tx_state == LINE_IDLE && tx_buffer_empty_flag) begin
            tx_pin_oe <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receiver
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_pin_owned <= 1'b0;
        end else begin
            rx_pin_owned <= receiver_enable;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || !receiver_enable) begin
            rx_state <= LINE_IDLE;
            rx_shift <= 9'h000;
            rx_bit   <= 4'd0;
            rx_par_err <= 1'b0;
        end else begin
            case (rx_state)
                LINE_IDLE: if (bit_tick && !rx_s && !rx_hold) begin
                    rx_bit   <= 4'd0;
                    rx_shift <= 9'h000;
                    rx_state <= LINE_DATA;
                end
                LINE_DATA: if (bit_tick) begin
                    rx_shift[rx_bit] <= rx_s;
                    rx_bit <= rx_bit + 4'd1;
                    if (rx_bit == nbits - 4'd1) begin
                        rx_state <= parity_enable_bit ? LINE_PARITY : LINE_STOP;
                    end
                end
                LINE_PARITY: if (bit_tick) begin
                    rx_par_err <= ^rx_shift ^ parity_odd_select ^ rx_s;
                    rx_state <= LINE_STOP;
                end
                LINE_STOP: if (bit_tick) begin
                    rx_state <= LINE_IDLE;
                end
                default: rx_state <= LINE_IDLE;
            endcase
        end
    end

    // holding slot in the shifter and overrun detection
    always_ff @(posedge aclk) begin
        if (!aresetn || !receiver_enable) begin
            rx_hold <= 1'b0;
            rx_held <= '0;
            overrun_pend <= 1'b0;
        end else begin
            if (rx_state == LINE_STOP && bit_tick) begin
                rx_hold <= 1'b1;
                rx_held.data       <= rx_shift;
                rx_held.frame_err  <= !rx_s;
                rx_held.parity_err <= parity_enable_bit & rx_par_err;
                rx_held.overrun    <= overrun_pend;
            end else if (rx_hold && (rx_count < 2'(RX_DEPTH) || rd_data)) begin
                rx_hold <= 1'b0;
            end
            if (rx_hold && rx_count == 2'(RX_DEPTH) && !rd_data
                && bit_tick && !rx_s) begin
                overrun_pend <= 1'b1;
                rx_held.overrun <= 1'b1;
            end else if (rx_hold && (rx_count < 2'(RX_DEPTH) || rd_data)) begin
                overrun_pend <= 1'b0;
            end
        end
    end

    // two-entry fifo with status per character
    always_ff @(posedge aclk) begin
        if (!aresetn || !receiver_enable) begin
            rx_count  <= 2'd0;
            rx_rd_ptr <= 1'b0;
        end else begin
            if (rx_hold && (rx_count < 2'(RX_DEPTH) || rd_data)) begin
                rx_fifo[rx_rd_ptr ^ rx_count[0]] <= rx_held;
            end
            if (rd_data) begin
                rx_rd_ptr <= ~rx_rd_ptr;
            end
            rx_count <= rx_count + 2'(rx_hold && (rx_count < 2'(RX_DEPTH) || rd_data))
                        - 2'(rd_data);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt requests, global masking done outside
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_rx_complete <= 1'b0;
            irq_tx_empty    <= 1'b0;
            irq_tx_complete <= 1'b0;
        end else begin
            irq_rx_complete <= rx_complete_flag & ctrl_b[RXCIE_POS];
            irq_tx_empty    <= tx_buffer_empty_flag & ctrl_b[UDRIE_POS];
            irq_tx_complete <= tx_complete_flag & ctrl_b[TXCIE_POS];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    empty_after_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_do && aw_addr == ADDR_DATA |=> !tx_buffer_empty_flag)
        else $error("buffer empty flag not cleared by data write");
    empty_irq_level_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_buffer_empty_flag && ctrl_b[UDRIE_POS] |=> irq_tx_empty)
        else $error("empty interrupt missing");
    complete_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(tx_complete_flag) && ctrl_b[TXCIE_POS] |=> irq_tx_complete)
        else $error("complete interrupt missing");
    complete_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_state == LINE_STOP && bit_tick && tx_buffer_empty_flag |=> tx_complete_flag)
        else $error("complete flag not set");
    rx_flush_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !receiver_enable |=> !rx_complete_flag)
        else $error("buffer not flushed");
    fifo_depth_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_count <= 2'(RX_DEPTH))
        else $error("receive buffer overfilled");
    pin_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !transmitter_enable && tx_state != LINE_IDLE |=> tx_pin_oe)
        else $error("pin released mid frame");
    rx_irq_a: assert property (@(posedge aclk) disable iff (!aresetn)
        rx_complete_flag && ctrl_b[RXCIE_POS] |=> irq_rx_complete)
        else $error("receive interrupt missing");
    tx_frame_c: cover property (@(posedge aclk) $rose(tx_complete_flag));
    rx_frame_c: cover property (@(posedge aclk) rx_count == 2'(RX_DEPTH));
    overrun_c:  cover property (@(posedge aclk) overrun_pend);

endmodule : serial_transceiver

// File: serial_pkg.sv
package serial_pkg;

    // register byte offsets on the lite bus
    localparam logic [7:0] ADDR_DATA     = 8'h00;
    localparam logic [7:0] ADDR_STATUS_A = 8'h04;
    localparam logic [7:0] ADDR_CTRL_B   = 8'h08;
    localparam logic [7:0] ADDR_CTRL_C   = 8'h0C;
    localparam logic [7:0] ADDR_BAUD     = 8'h10;

    // control_status_a bit positions
    localparam int RXC_POS  = 7;
    localparam int TXC_POS  = 6;
    localparam int UDRE_POS = 5;
    localparam int FE_POS   = 4;
    localparam int DOR_POS  = 3;
    localparam int PE_POS   = 2;

    // control_status_b bit positions
    localparam int RXCIE_POS = 7;
    localparam int TXCIE_POS = 6;
    localparam int UDRIE_POS = 5;
    localparam int RXEN_POS  = 4;
    localparam int TXEN_POS  = 3;
    localparam int RXB8_POS  = 1;
    localparam int TXB8_POS  = 0;

    // control_c fields
    localparam int SIZE_LSB   = 0;
    localparam int PODD_POS   = 3;
    localparam int PEN_POS    = 4;
    localparam int SYNC_POS   = 5;

    localparam logic [2:0] SIZE_NINE  = 3'h7;
    localparam logic [2:0] SIZE_EIGHT = 3'h3;
    localparam logic [15:0] BAUD_RESET = 16'h0033;
    localparam int RX_DEPTH = 2;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // one received character with its status bits
    typedef struct packed {
        logic [8:0] data;
        logic       frame_err;
        logic       overrun;
        logic       parity_err;
    } rx_entry_t;

    typedef enum logic [2:0] {
        LINE_IDLE   = 3'b000,
        LINE_START  = 3'b001,
        LINE_DATA   = 3'b011,
        LINE_PARITY = 3'b010,
        LINE_STOP   = 3'b110,
        LINE_STOP2  = 3'b111
    } line_state_t;

endpackage : serial_pkg

// File: serial_remote.sv
`timescale 1ns/1ns
// line-side model of the remote node, BIT cycles per bit
module serial_remote #(parameter int BIT = 4) (
    input  wire logic aclk,       // system clock
    output logic      rx_pin,     // line into the device
    input  wire logic tx_pin_out, // device transmit data
    input  wire logic tx_pin_oe   // device drives its line
);
    logic [9:0] got[$];
    logic [9:0] cap;
    wire        tx_line = tx_pin_oe ? tx_pin_out : 1'b1; // released line pulls high

    initial rx_pin = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // one bit on the line, changed just after an edge
    task automatic put(input bit b);
        rx_pin <= b;
        repeat (BIT) @(posedge aclk);
    endtask : put

    // start, data lsb first, optional even parity, stop, then a second stop
    task automatic send(input logic [8:0] d, input int nb, input bit pen, input bit flip,
                        input bit stop);
        put(1'b0);
        for (int i = 0; i < nb; i++) put(d[i]);
        if (pen) put(^d[7:0] ^ flip);
        put(stop);
        put(1'b1);
    endtask : send

    // capture 8 data bits, parity and stop of each outgoing frame
    initial forever begin
        @(negedge tx_line);
        repeat (BIT / 2) @(posedge aclk);
        for (int i = 0; i < 10; i++) begin
            repeat (BIT) @(posedge aclk);
            cap[i] = tx_line;
        end
        got.push_back(cap);
    end
endmodule : serial_remote

// File: test_usart_buffer_flags_and_interrupts.sv
`timescale 1ns/1ns
module test_usart_buffer_flags_and_interrupts;
    import serial_pkg::*;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic        s_axi_rready, rx_pin, sync_transfer_clock_pin, tx_complete_ack, tx_pin_out;
    logic        tx_pin_oe, rx_pin_owned, irq_rx_complete, irq_tx_empty, irq_tx_complete;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, r;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    int          n_fail = 0;
    int          checks = 0;
    logic [1:0]  xc = 2'b00;

    // free-running external transfer clock, one rise every four cycles
    always @(posedge aclk) begin
        xc <= xc + 2'b01;
        sync_transfer_clock_pin <= xc[1];
    end

    serial_transceiver serial_transceiver_i (.*);
    serial_remote #(.BIT(4)) serial_remote_i (.aclk(aclk), .rx_pin(rx_pin),
        .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe));

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (n_fail == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // bound on every handshake or flag wait
    task automatic late(input int n);
        if (n > 400) begin
            n_fail++;
            stop_test();
        end
    endtask : late

    task automatic wt(ref logic s);
        for (int n = 0; s !== 1'b1; n++) begin
            @(posedge aclk);
            late(n);
        end
    endtask : wt

    // lite write: each channel released at its own handshake edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b = 1'b0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        for (int n = 0; !b; n++) begin
            @(negedge aclk);
            {aw, w, b} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
            @(posedge aclk);
            late(n);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        logic ar, v = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        for (int n = 0; !v; n++) begin
            @(negedge aclk);
            {ar, v, r, resp} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge aclk);
            late(n);
            if (ar) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        rd(a);
        chk(r[7:0] & m, e);
    endtask : rc

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} <= '0;
        {s_axi_rready, tx_complete_ack} <= '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
        s_axi_wstrb <= 4'hf;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rc(ADDR_STATUS_A, 8'hff, 8'h20);
        rd(8'h14);
        chk(resp, RESP_SLVERR);
        wr(ADDR_BAUD, 32'h0000_0003);
        wr(ADDR_CTRL_C, 32'h0000_0013);
        wr(ADDR_CTRL_B, 32'h0000_00f8);
        @(negedge aclk);
        chk(irq_tx_empty, 1'b1);
        chk(rx_pin_owned, 1'b1);
        wr(ADDR_DATA, 32'h0000_00a5);
        wr(ADDR_DATA, 32'h0000_0007);
        rc(ADDR_STATUS_A, 8'h20, 8'h00);
        for (int n = 0; serial_remote_i.got.size() < 2; n++) begin
            @(posedge aclk);
            late(n);
        end
        chk(serial_remote_i.got[0], 10'h2a5);
        chk(serial_remote_i.got[1], 10'h307);
        wt(irq_tx_complete);
        rc(ADDR_STATUS_A, 8'h60, 8'h60);
        wr(ADDR_STATUS_A, 32'h0000_0040);
        rc(ADDR_STATUS_A, 8'h40, 8'h00);
        wr(ADDR_DATA, 32'h0000_0011);
        wr(ADDR_CTRL_B, 32'h0000_00f0);
        @(negedge aclk);
        chk(tx_pin_oe, 1'b1);
        wt(irq_tx_complete);
        tx_complete_ack <= 1'b1;
        @(posedge aclk);
        tx_complete_ack <= 1'b0;
        rc(ADDR_STATUS_A, 8'h40, 8'h00);
        chk(tx_pin_oe, 1'b0);
        serial_remote_i.send(9'h03c, 8, 1'b1, 1'b0, 1'b1);
        serial_remote_i.send(9'h081, 8, 1'b1, 1'b1, 1'b0);
        wt(irq_rx_complete);
        rc(ADDR_STATUS_A, 8'h9c, 8'h80);
        rc(ADDR_DATA, 8'hff, 8'h3c);
        rc(ADDR_STATUS_A, 8'h9c, 8'h94);
        rc(ADDR_DATA, 8'hff, 8'h81);
        rc(ADDR_STATUS_A, 8'h80, 8'h00);
        wr(ADDR_CTRL_C, 32'h0000_0007);
        serial_remote_i.send(9'h155, 9, 1'b0, 1'b0, 1'b1);
        rc(ADDR_CTRL_B, 8'h02, 8'h02);
        rc(ADDR_DATA, 8'hff, 8'h55);
        wr(ADDR_CTRL_C, 32'h0000_0023);
        serial_remote_i.send(9'h05a, 8, 1'b0, 1'b0, 1'b1);
        rc(ADDR_DATA, 8'hff, 8'h5a);
        wr(ADDR_CTRL_C, 32'h0000_0000);
        serial_remote_i.send(9'h0ff, 5, 1'b0, 1'b0, 1'b1);
        rc(ADDR_DATA, 8'hff, 8'h1f);
        serial_remote_i.send(9'h0aa, 5, 1'b0, 1'b0, 1'b1);
        wr(ADDR_CTRL_B, 32'h0000_0000);
        rc(ADDR_STATUS_A, 8'h80, 8'h00);
        chk(rx_pin_owned, 1'b0);
        stop_test();
    end
endmodule : test_usart_buffer_flags_and_interrupts
